// ==== pcd_detector.sv ====
/*
  Pin-change interrupt detector with AXI4-Lite register slave.
  Assumes the pads deliver both a Schmitt and a TTL copy of every pin,
  and that the core treats wake_req as a level.
*/
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
// Contract
// - Select bit picks Schmitt or TTL path
// - Threshold select bits 7-6 read zero
// - Change detection enabled per pin independently
// - Master enable off still sets flags
// - Rise detector gated by rise enable bit
// - Fall detector gated by fall enable bit
// - Both enables flag either edge direction
// - Enabled edge sets flag; irq needs master
// - Summary flag is OR of pin flags
// - Writing zero clears a pin flag
// - Edge during clearing write keeps flag set
// - Change event wakes from sleep if enabled
// - Flags update before first post-wake instruction
// - Master enable bit 3, summary bit 0
// - Six-bit registers, upper bits zero, reset zero
module pcd_detector #(
  parameter int unsigned PINS = pcd_pkg::NUM_PINS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PINS-1:0] pin_schmitt,
  input wire logic [PINS-1:0] pin_ttl,
  output logic [PINS-1:0] port_read,
  output logic irq,
  output logic wake_req,
  input wire logic [pcd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [PINS-1:0] thresh_q;
  logic [PINS-1:0] rise_en_q;
  logic [PINS-1:0] fall_en_q;
  logic [PINS-1:0] flags_q;
  logic [PINS-1:0] flags_d;
  logic [PINS-1:0] mask_q;
  logic master_en_q;
  logic [PINS-1:0] sel_pin;
  logic [PINS-1:0] rise_p;
  logic [PINS-1:0] fall_p;
  logic [PINS-1:0] event_p;
  logic summary;

  logic aw_hold_q;
  logic w_hold_q;
  logic [pcd_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] rd_word;
  logic rd_ok;

  // Pads are selected before synchronising so both port reads and edges see one path
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      assign sel_pin[g] = thresh_q[g] ? pin_schmitt[g] : pin_ttl[g];
      pcd_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(sel_pin[g]),
        .level(port_read[g]),
        .rise(rise_p[g]),
        .fall(fall_p[g])
      );
    end
  endgenerate

  assign event_p = (rise_p & rise_en_q) | (fall_p & fall_en_q);
  assign summary = |flags_q;

  // Interrupt gated by the master enable and the mask; wake gated by the master enable only, not the mask
  assign irq = master_en_q & |(flags_q & mask_q);
  assign wake_req = master_en_q & summary;

  // Write channel: address and data captured in either order
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  assign wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    if (awaddr_q[4:2] > pcd_pkg::OFF_MASK[4:2]) begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? pcd_pkg::RESP_OKAY : pcd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; all fields live in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thresh_q <= pcd_pkg::PIN_RESET;
      rise_en_q <= pcd_pkg::PIN_RESET;
      fall_en_q <= pcd_pkg::PIN_RESET;
      mask_q <= pcd_pkg::PIN_RESET;
      master_en_q <= 1'b0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (awaddr_q == pcd_pkg::OFF_THRESH) begin
        thresh_q <= wdata_q[PINS-1:0];
      end else if (awaddr_q == pcd_pkg::OFF_RISE) begin
        rise_en_q <= wdata_q[PINS-1:0];
      end else if (awaddr_q == pcd_pkg::OFF_FALL) begin
        fall_en_q <= wdata_q[PINS-1:0];
      end else if (awaddr_q == pcd_pkg::OFF_CORE) begin
        master_en_q <= wdata_q[pcd_pkg::CORE_MEN_BIT];
      end else if (awaddr_q == pcd_pkg::OFF_MASK) begin
        mask_q <= wdata_q[PINS-1:0];
      end
    end
  end

  // Flags: a written zero clears, a same-cycle edge always wins
  always_comb begin
    flags_d = flags_q;
    if (wr_fire && wstrb_q[0] && awaddr_q == pcd_pkg::OFF_FLAGS) begin
      flags_d = flags_q & wdata_q[PINS-1:0];
    end
    flags_d = flags_d | event_p;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= pcd_pkg::PIN_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Read channel: data registered, one read at a time
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    if (s_axi_araddr == pcd_pkg::OFF_THRESH) begin
      rd_word[PINS-1:0] = thresh_q;
    end else if (s_axi_araddr == pcd_pkg::OFF_RISE) begin
      rd_word[PINS-1:0] = rise_en_q;
    end else if (s_axi_araddr == pcd_pkg::OFF_FALL) begin
      rd_word[PINS-1:0] = fall_en_q;
    end else if (s_axi_araddr == pcd_pkg::OFF_FLAGS) begin
      rd_word[PINS-1:0] = flags_q;
    end else if (s_axi_araddr == pcd_pkg::OFF_CORE) begin
      rd_word[pcd_pkg::CORE_MEN_BIT] = master_en_q;
      rd_word[pcd_pkg::CORE_SUM_BIT] = summary;
    end else if (s_axi_araddr == pcd_pkg::OFF_MASK) begin
      rd_word[PINS-1:0] = mask_q;
    end else if (s_axi_araddr[1:0] != 2'h0) begin
      rd_word = '0;
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pcd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? pcd_pkg::RESP_OKAY : pcd_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pcd_detector

// ==== pcd_pkg.sv ====
/*
  Constants shared by the pin-change interrupt detector: register byte
  offsets, field positions and reset values.
  Assumes an AXI4-Lite register bus with 32-bit data, one word per register.
*/
package pcd_pkg;
  localparam int unsigned NUM_PINS = 6;
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFF_THRESH = 5'h00;
  localparam logic [4:0] OFF_RISE = 5'h04;
  localparam logic [4:0] OFF_FALL = 5'h08;
  localparam logic [4:0] OFF_FLAGS = 5'h0C;
  localparam logic [4:0] OFF_CORE = 5'h10;
  localparam logic [4:0] OFF_MASK = 5'h14;
  localparam int unsigned CORE_MEN_BIT = 3;
  localparam int unsigned CORE_SUM_BIT = 0;
  localparam logic [5:0] PIN_RESET = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pcd_pkg

// ==== pcd_pin_sync.sv ====
/*
  Two-flop synchroniser with edge pulses for one pin.
  Assumes the pin level is asynchronous to aclk.
*/
`timescale 1ns/10ps
module pcd_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule : pcd_pin_sync

// ==== pcd_pads.sv ====
/* Pin source for the detector bench: both pad copies of every pin.
   Assumes the bench sets the level and which pins read apart on TTL. */
`timescale 1ns/10ps
module pcd_pads (
  input wire logic [5:0] lvl,
  input wire logic [5:0] skew,
  output logic [5:0] pin_schmitt,
  output logic [5:0] pin_ttl
);
  // A slow edge near threshold may read opposite on the TTL copy
  assign pin_schmitt = lvl;
  assign pin_ttl = lvl ^ skew;
endmodule : pcd_pads

// ==== pcd_checker.sv ====
/* Port checker for pcd_detector, bound into every instance.
   Assumes one clock domain with synchronous active-low reset. */
`timescale 1ns/10ps
module pcd_checker #(
  parameter int unsigned PINS = pcd_pkg::NUM_PINS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PINS-1:0] pin_schmitt,
  input wire logic [PINS-1:0] pin_ttl,
  input wire logic [PINS-1:0] port_read,
  input wire logic irq,
  input wire logic wake_req,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_quiet_a:
    assert property (disable iff (1'b0) !aresetn |=> !irq && !wake_req && port_read == '0)
      else $error("outputs active after reset");
  irq_wake_a: assert property (irq |-> wake_req) else $error("irq without wake");
  port_track_a:
    assert property ((pin_schmitt == pin_ttl && $stable(pin_schmitt))[*3]
      |=> port_read == $past(pin_schmitt)) else $error("port read off");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read late");
  read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read repeated");
  write_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write repeated");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  cover property (irq);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(port_read[0]));
endmodule : pcd_checker
bind pcd_detector pcd_checker #(.PINS(PINS)) chk_i (.*);

// ==== pcd_detector_bench.sv ====
/* Bench for pcd_detector: edge table, then register, irq and reset checks.
   Assumes pcd_pads drives both pin copies. */
`timescale 1ns/10ps
module pcd_detector_bench;
  typedef struct packed {logic [5:0] thr, sk, ri, fa, p0, p1, ex;} pcd_row_t;
  pcd_row_t rows [4] = '{
    '{6'h3f, 6'h00, 6'h3f, 6'h00, 6'h00, 6'h15, 6'h15},
    '{6'h3f, 6'h00, 6'h00, 6'h3f, 6'h3f, 6'h0c, 6'h33},
    '{6'h3f, 6'h00, 6'h05, 6'h05, 6'h01, 6'h0c, 6'h05},
    '{6'h00, 6'h3f, 6'h3f, 6'h00, 6'h3f, 6'h00, 6'h3f}};
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, irq, wake_req, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
  logic [5:0] lvl = 0, skew = 0, pin_schmitt, pin_ttl, port_read;
  int num_errors = 0, checks = 0;
  pcd_detector dut (.*);
  pcd_pads pads (.*);
  always #50 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n == 40) begin
      num_errors++;
      final_report();
    end
  endtask : tmo
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    q = s_axi_rdata;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask : rd
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk("register", e, q);
  endtask : rc
  task automatic final_report;
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      wr(pcd_pkg::OFF_RISE, 0);
      wr(pcd_pkg::OFF_FALL, 0);
      wr(pcd_pkg::OFF_THRESH, rows[i].thr);
      {lvl, skew} <= {rows[i].p0, rows[i].sk};
      repeat (5) @(posedge aclk);
      wr(pcd_pkg::OFF_FLAGS, 0);
      wr(pcd_pkg::OFF_RISE, rows[i].ri);
      wr(pcd_pkg::OFF_FALL, rows[i].fa);
      lvl <= rows[i].p1;
      repeat (5) @(posedge aclk);
      rc(pcd_pkg::OFF_FLAGS, rows[i].ex);
      chk("port_read", rows[i].p1 ^ (rows[i].sk & ~rows[i].thr), port_read);
    end
    rc(pcd_pkg::OFF_CORE, 32'h1);
    wr(pcd_pkg::OFF_MASK, 32'h3f);
    chk("irq", 0, irq);
    wr(pcd_pkg::OFF_CORE, 32'h8);
    rc(pcd_pkg::OFF_CORE, 32'h9);
    chk("irq", 1, irq);
    chk("wake_req", 1, wake_req);
    wr(pcd_pkg::OFF_FLAGS, 32'h3c);
    rc(pcd_pkg::OFF_FLAGS, 32'h3c);
    rd(pcd_pkg::OFF_FLAGS);
    wr(pcd_pkg::OFF_FLAGS, q & (q ^ 32'hff));
    rc(pcd_pkg::OFF_CORE, 32'h8);
    chk("irq", 0, irq);
    wr(pcd_pkg::OFF_FALL, 32'h3f);
    skew <= 6'h0;
    wr(pcd_pkg::OFF_FLAGS, 0);
    repeat (3) @(posedge aclk);
    rc(pcd_pkg::OFF_FLAGS, 32'h3f);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) rc(5'(a), 0);
    wr(pcd_pkg::OFF_THRESH, 32'hff);
    rc(pcd_pkg::OFF_THRESH, 32'h3f);
    rd(5'h18);
    chk("rresp", pcd_pkg::RESP_SLVERR, s_axi_rresp);
    final_report();
  end
endmodule : pcd_detector_bench
